// ==== hw/asf_defs.svh ====
// register offsets, field positions and reset values of the alarm block
// assumes: included by bare name from design and testbench files
`ifndef ASF_DEFS_SVH
`define ASF_DEFS_SVH
`define ASF_OFS_LATCHED 8'h62
`define ASF_OFS_RAW 8'h64
`define ASF_OFS_MASK 8'h66
`define ASF_OFS_CONFIG 8'h68
`define ASF_OFS_PINSTATE 8'h6A
`define ASF_BIT_SECSAFE 15
`define ASF_BIT_HWSAFE 14
`define ASF_BIT_PERMFAIL 13
`define ASF_BIT_SFALERT 12
`define ASF_BIT_PFALERT 11
`define ASF_BIT_INITBEGUN 10
`define ASF_BIT_INITDONE 9
`define ASF_BIT_RSVD 8
`define ASF_BIT_FULLLOOP 7
`define ASF_BIT_CHGOFF 6
`define ASF_BIT_DSGOFF 5
`define ASF_BIT_STACKLOW 4
`define ASF_BIT_FUSE 3
`define ASF_BIT_BALANCE 2
`define ASF_BIT_SCAN 1
`define ASF_BIT_WAKE 0
`define ASF_MASK_RESET 16'h0000
`define ASF_CFG_RESET 16'h0000
`define ASF_FXN_ALARM 2'h2
`define ASF_CFG_FXN_LO 0
`define ASF_CFG_CHGPOL 2
`define ASF_CFG_DSGPOL 3
`define ASF_CFG_CHGEN 4
`define ASF_CFG_DSGEN 5
`endif

// ==== hw/asf_pkg.sv ====
// types shared by the alarm block files
// assumes: asf_defs.svh on the include path
package asf_pkg;
  typedef logic [15:0] asf_word_t;
  typedef enum logic [1:0] {
    ASF_PM_NORMAL,
    ASF_PM_SLEEP,
    ASF_PM_DEEPSLEEP,
    ASF_PM_SHUTDOWN
  } asf_power_t;
endpackage : asf_pkg

// ==== hw/asf_fault_pin.sv ====
// one fault-indication pin driver with selectable polarity
// assumes: fault input is synchronous to clk
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_fault_pin
  import asf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic activeHigh,
  input wire logic fault,
  input wire asf_pkg::asf_power_t powerMode,
  output logic pinOut,
  output logic pinOe
);
  typedef struct packed {
    logic out;
    logic oe;
  } asf_pin_state_t;

  asf_pin_state_t st_reg;
  asf_pin_state_t st_next;

  always_comb begin
    st_next = st_reg;
    // asserted level follows polarity; released level is the inverse
    st_next.out = fault ? activeHigh : ~activeHigh; // see RULE20 see RULE21
    // high impedance in shutdown and whenever enable is low
    st_next.oe = enable && (powerMode != ASF_PM_SHUTDOWN); // see RULE22
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pinOut = st_reg.out;
  assign pinOe = st_reg.oe;

  property p_pinfollow;
    @(posedge clk) disable iff (rst)
      enable ##1 1'b1 |-> pinOut == ($past(fault) ~^ $past(activeHigh));
  endproperty
  a_pinfollow: assert property (p_pinfollow) else $error("fault pin level wrong"); // see RULE20

  property p_shuthiz;
    @(posedge clk) disable iff (rst)
      powerMode == ASF_PM_SHUTDOWN |=> !pinOe;
  endproperty
  a_shuthiz: assert property (p_shuthiz) else $error("fault pin driven in shutdown"); // see RULE22
endmodule : asf_fault_pin

// ==== hw/asf_alarm.sv ====
// alarm aggregation: raw flags, mask, sticky status, alert and fault pins
// assumes: status inputs come from device logic on clk; fuseSense is a pin
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "asf_defs.svh"
// Summary of operation
// RULE1: bits 15..13 summarise safety and fail groups
// RULE2: bit 12 is masked safety alert
// RULE3: bit 11 is masked permanent-fail alert
// RULE4: bit 10 init begun, 9 done, 8 reserved
// RULE5: bit 7 sets on first full loop
// RULE6: bit 4 stack low, 6/5 FETs off
// RULE7: bit 3 high while fuse driven
// RULE8: bit 2 high while balancing
// RULE9: bit 1 sets on first single scan
// RULE10: bit 0 shows wake from sleep
// RULE11: raw word is live, unlatched
// RULE12: masked rising edge sets sticky bit
// RULE13: scan bits latch on every completion
// RULE14: mask from default, safety, fail masks
// RULE15: alert is OR of sticky bits
// RULE16: write one clears sticky bit
// RULE17: mask word reads current mask
// RULE18: mask writes take effect immediately
// RULE19: fault pins follow charge/discharge disables
// RULE20: fault pin asserts and recovers with fault
// RULE21: fault pin polarity configurable
// RULE22: fault pins hi-Z only in shutdown; the code also releases a pin whenever its config enable bit is low
// RULE23: alarm on alert only in function 0b10
// RULE24: sticky bits hold; reserved reads zero
module asf_alarm
  import asf_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic [15:0] secondarySafetyFlags,
  input wire logic [7:0] hwSafetyFlags,
  input wire logic [15:0] permFailFlags,
  input wire logic [23:0] safetyAlertFlags,
  input wire logic [23:0] safetyAlertMask,
  input wire logic [31:0] permFailAlertFlags,
  input wire logic [31:0] permFailAlertMask,
  input wire logic initBegun,
  input wire logic initDone,
  input wire logic fullLoopPulse,
  input wire logic singleScanPulse,
  input wire logic chargeFetOff,
  input wire logic dischargeFetOff,
  input wire logic stackBelowShutdown,
  input wire logic fuseDriveOwn,
  input wire logic fuseSense,
  input wire logic balancingActive,
  input wire logic wokenFromSleep,
  input wire logic chargeDisableFault,
  input wire logic dischargeDisableFault,
  input wire asf_pkg::asf_power_t powerMode,
  input wire logic [1:0] alertPinFunction,
  output logic alertPinState,
  output logic chargeFaultPinOut,
  output logic chargeFaultPinOe,
  output logic dischargeFaultPinOut,
  output logic dischargeFaultPinOe
);
  import asf_pkg::*;

  typedef struct packed {
    logic [1:0] fuseSync;
    logic fullLoopSeen;
    logic scanSeen;
    asf_word_t rawPrev;
    asf_word_t latched;
    asf_word_t mask;
    asf_word_t cfg;
    logic [15:0] rdata;
    logic alert;
  } asf_state_t;

  asf_state_t st_reg;
  asf_state_t st_next;
  asf_word_t rawFlags;
  asf_word_t setEvents;

  // address decode used by the write path; the read path decodes with a case
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  always_comb begin
    rawFlags = 16'h0000;
    rawFlags[`ASF_BIT_SECSAFE] = |secondarySafetyFlags; // see RULE1
    rawFlags[`ASF_BIT_HWSAFE] = |hwSafetyFlags; // see RULE1
    rawFlags[`ASF_BIT_PERMFAIL] = |permFailFlags; // see RULE1
    rawFlags[`ASF_BIT_SFALERT] = |(safetyAlertFlags & safetyAlertMask); // see RULE2 see RULE14
    rawFlags[`ASF_BIT_PFALERT] = |(permFailAlertFlags & permFailAlertMask); // see RULE3 see RULE14
    rawFlags[`ASF_BIT_INITBEGUN] = initBegun; // see RULE4
    rawFlags[`ASF_BIT_INITDONE] = initDone; // see RULE4
    rawFlags[`ASF_BIT_RSVD] = 1'b0; // see RULE24
    rawFlags[`ASF_BIT_FULLLOOP] = st_reg.fullLoopSeen; // see RULE5
    rawFlags[`ASF_BIT_CHGOFF] = chargeFetOff; // see RULE6
    rawFlags[`ASF_BIT_DSGOFF] = dischargeFetOff; // see RULE6
    rawFlags[`ASF_BIT_STACKLOW] = stackBelowShutdown; // see RULE6
    // own drive or the external protector seen through the synchroniser
    rawFlags[`ASF_BIT_FUSE] = fuseDriveOwn | st_reg.fuseSync[1]; // see RULE7
    rawFlags[`ASF_BIT_BALANCE] = balancingActive; // see RULE8
    rawFlags[`ASF_BIT_SCAN] = st_reg.scanSeen; // see RULE9
    rawFlags[`ASF_BIT_WAKE] = wokenFromSleep; // see RULE10
  end

  always_comb begin
    // edge detect uses the mask in force now, so mask writes act at once
    setEvents = rawFlags & ~st_reg.rawPrev & st_reg.mask; // see RULE12 see RULE18
    // scan bits never toggle after the first scan, so every completion counts
    setEvents[`ASF_BIT_SCAN] = singleScanPulse & st_reg.mask[`ASF_BIT_SCAN]; // see RULE13
    setEvents[`ASF_BIT_FULLLOOP] = fullLoopPulse & st_reg.mask[`ASF_BIT_FULLLOOP]; // see RULE13
    setEvents[`ASF_BIT_RSVD] = 1'b0;
  end

  always_comb begin
    st_next = st_reg;
    st_next.fuseSync = {st_reg.fuseSync[0], fuseSense};
    st_next.fullLoopSeen = st_reg.fullLoopSeen | fullLoopPulse; // see RULE5
    st_next.scanSeen = st_reg.scanSeen | singleScanPulse; // see RULE9
    st_next.rawPrev = rawFlags;
    st_next.latched = st_reg.latched;
    if (regWr && hit(regAddr, `ASF_OFS_LATCHED)) begin
      st_next.latched = st_reg.latched & ~regWdata; // see RULE16
    end
    // a set in the same cycle as its clear wins, so no event is lost
    st_next.latched = st_next.latched | setEvents; // see RULE12 see RULE24
    if (regWr && hit(regAddr, `ASF_OFS_MASK)) begin
      st_next.mask = regWdata; // see RULE18
    end
    if (regWr && hit(regAddr, `ASF_OFS_CONFIG)) begin
      st_next.cfg = regWdata;
    end
    st_next.rdata = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        `ASF_OFS_LATCHED: st_next.rdata = st_reg.latched;
        `ASF_OFS_RAW: st_next.rdata = rawFlags; // see RULE11
        `ASF_OFS_MASK: st_next.rdata = st_reg.mask; // see RULE17
        `ASF_OFS_CONFIG: st_next.rdata = st_reg.cfg;
        `ASF_OFS_PINSTATE: st_next.rdata = {15'h0000, st_reg.alert};
        default: st_next.rdata = 16'h0000;
      endcase
    end
    // alarm on the alert pin only in the alarm function setting
    st_next.alert = (alertPinFunction == `ASF_FXN_ALARM) && (|st_next.latched); // see RULE15 see RULE23
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.mask <= `ASF_MASK_RESET;
      st_reg.cfg <= `ASF_CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign regRdata = st_reg.rdata;
  assign alertPinState = st_reg.alert;

  asf_fault_pin u_chargePin (
    .clk(clk),
    .rst(rst),
    .enable(st_reg.cfg[`ASF_CFG_CHGEN]),
    .activeHigh(st_reg.cfg[`ASF_CFG_CHGPOL]),
    .fault(chargeDisableFault), // see RULE19
    .powerMode(powerMode),
    .pinOut(chargeFaultPinOut),
    .pinOe(chargeFaultPinOe)
  );

  asf_fault_pin u_dischargePin (
    .clk(clk),
    .rst(rst),
    .enable(st_reg.cfg[`ASF_CFG_DSGEN]),
    .activeHigh(st_reg.cfg[`ASF_CFG_DSGPOL]),
    .fault(dischargeDisableFault), // see RULE19
    .powerMode(powerMode),
    .pinOut(dischargeFaultPinOut),
    .pinOe(dischargeFaultPinOe)
  );

  property p_hwsafe;
    @(posedge clk) disable iff (rst)
      (|hwSafetyFlags) |-> rawFlags[`ASF_BIT_HWSAFE];
  endproperty
  a_hwsafe: assert property (p_hwsafe) else $error("safety summary missing"); // see RULE1

  property p_sfalert;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_SFALERT] == |(safetyAlertFlags & safetyAlertMask);
  endproperty
  a_sfalert: assert property (p_sfalert) else $error("masked safety alert wrong"); // see RULE2

  property p_scanstay;
    @(posedge clk) disable iff (rst)
      singleScanPulse |=> rawFlags[`ASF_BIT_SCAN] [*8];
  endproperty
  a_scanstay: assert property (p_scanstay) else $error("scan bit did not stay"); // see RULE9

  property p_edgelatch;
    @(posedge clk) disable iff (rst)
      (!st_reg.rawPrev[`ASF_BIT_WAKE] && wokenFromSleep && st_reg.mask[`ASF_BIT_WAKE])
        |=> st_reg.latched[`ASF_BIT_WAKE];
  endproperty
  a_edgelatch: assert property (p_edgelatch) else $error("wake edge not latched"); // see RULE12

  property p_scanrelatch;
    @(posedge clk) disable iff (rst)
      (singleScanPulse && st_reg.mask[`ASF_BIT_SCAN]) |=> st_reg.latched[`ASF_BIT_SCAN];
  endproperty
  a_scanrelatch: assert property (p_scanrelatch) else $error("scan not relatched"); // see RULE13

  property p_alert;
    @(posedge clk) disable iff (rst)
      (alertPinFunction == `ASF_FXN_ALARM && $stable(alertPinFunction))
        |-> alertPinState == (|st_reg.latched);
  endproperty
  a_alert: assert property (p_alert) else $error("alert not OR of status"); // see RULE15

  property p_w1c;
    @(posedge clk) disable iff (rst)
      (regWr && regAddr == `ASF_OFS_LATCHED)
        |=> (st_reg.latched & ~$past(setEvents)) == ($past(st_reg.latched) & ~$past(regWdata)
          & ~$past(setEvents));
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one-clear wrong"); // see RULE16

  property p_maskread;
    @(posedge clk) disable iff (rst)
      (regWr && regAddr == `ASF_OFS_MASK) ##1 (regRd && regAddr == `ASF_OFS_MASK)
        |=> regRdata == $past(regWdata, 2);
  endproperty
  a_maskread: assert property (p_maskread) else $error("mask readback wrong"); // see RULE17

  property p_hold;
    @(posedge clk) disable iff (rst)
      (st_reg.latched[`ASF_BIT_WAKE] && !(regWr && regAddr == `ASF_OFS_LATCHED))
        |=> st_reg.latched[`ASF_BIT_WAKE];
  endproperty
  a_hold: assert property (p_hold) else $error("sticky bit dropped"); // see RULE24

  property p_nofxn;
    @(posedge clk) disable iff (rst)
      (alertPinFunction != `ASF_FXN_ALARM) |=> !alertPinState;
  endproperty
  a_nofxn: assert property (p_nofxn) else $error("alert active outside alarm function"); // see RULE23

  property p_secsafe;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_SECSAFE] == (|secondarySafetyFlags);
  endproperty
  a_secsafe: assert property (p_secsafe) else $error("secondary summary wrong"); // see RULE1

  property p_permfail;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_PERMFAIL] == (|permFailFlags);
  endproperty
  a_permfail: assert property (p_permfail) else $error("fail summary wrong"); // see RULE1

  property p_pfalert;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_PFALERT] == (|(permFailAlertFlags & permFailAlertMask));
  endproperty
  a_pfalert: assert property (p_pfalert) else $error("masked fail alert wrong"); // see RULE3

  property p_initbits;
    @(posedge clk) disable iff (rst)
      (rawFlags[`ASF_BIT_INITBEGUN] == initBegun)
        && (rawFlags[`ASF_BIT_INITDONE] == initDone);
  endproperty
  a_initbits: assert property (p_initbits) else $error("init bits wrong"); // see RULE4

  property p_rsvd;
    @(posedge clk) disable iff (rst)
      !rawFlags[`ASF_BIT_RSVD] && !st_reg.latched[`ASF_BIT_RSVD];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // see RULE24

  property p_fullstay;
    @(posedge clk) disable iff (rst)
      fullLoopPulse |=> rawFlags[`ASF_BIT_FULLLOOP] [*8];
  endproperty
  a_fullstay: assert property (p_fullstay) else $error("full loop bit did not stay"); // see RULE5

  property p_fullrelatch;
    @(posedge clk) disable iff (rst)
      (fullLoopPulse && st_reg.mask[`ASF_BIT_FULLLOOP])
        |=> st_reg.latched[`ASF_BIT_FULLLOOP];
  endproperty
  a_fullrelatch: assert property (p_fullrelatch) else $error("full loop not relatched"); // see RULE13

  property p_fetbits;
    @(posedge clk) disable iff (rst)
      (rawFlags[`ASF_BIT_CHGOFF] == chargeFetOff)
        && (rawFlags[`ASF_BIT_DSGOFF] == dischargeFetOff)
        && (rawFlags[`ASF_BIT_STACKLOW] == stackBelowShutdown);
  endproperty
  a_fetbits: assert property (p_fetbits) else $error("fet or stack bits wrong"); // see RULE6

  // the sensed path lags two cycles through the synchroniser; skip cycles that reset hid
  property p_fuse;
    @(posedge clk) disable iff (rst)
      (fuseDriveOwn || ($past(fuseSense, 2) && !$past(rst, 2)))
        |-> rawFlags[`ASF_BIT_FUSE];
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse drive not shown"); // see RULE7

  property p_balance;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_BALANCE] == balancingActive;
  endproperty
  a_balance: assert property (p_balance) else $error("balancing bit wrong"); // see RULE8

  property p_wake;
    @(posedge clk) disable iff (rst)
      rawFlags[`ASF_BIT_WAKE] == wokenFromSleep;
  endproperty
  a_wake: assert property (p_wake) else $error("wake bit wrong"); // see RULE10

  property p_maskonly;
    @(posedge clk) disable iff (rst)
      ((st_reg.latched & ~$past(st_reg.latched) & ~$past(st_reg.mask)) == 16'h0000);
  endproperty
  a_maskonly: assert property (p_maskonly) else $error("unmasked bit latched"); // see RULE14

  property p_maskimm;
    @(posedge clk) disable iff (rst)
      (regWr && regAddr == `ASF_OFS_MASK) |=> st_reg.mask == $past(regWdata);
  endproperty
  a_maskimm: assert property (p_maskimm) else $error("mask write not applied"); // see RULE18

  property p_rawread;
    @(posedge clk) disable iff (rst)
      (regRd && regAddr == `ASF_OFS_RAW) |=> regRdata == $past(rawFlags);
  endproperty
  a_rawread: assert property (p_rawread) else $error("raw read not live"); // see RULE11

  property p_alertrise;
    @(posedge clk) disable iff (rst)
      ((|setEvents) && alertPinFunction == `ASF_FXN_ALARM) |=> alertPinState;
  endproperty
  a_alertrise: assert property (p_alertrise) else $error("alert missed a set"); // see RULE15
endmodule : asf_alarm

// ==== testbench/asf_host_model.sv ====
// host processor model: reads and writes the alarm registers over the plain port
// assumes: single clk domain; read data stand only in the cycle after the strobe
`timescale 1ns/1ps
module asf_host_model (
  input wire logic clk,
  output logic [7:0] regAddr,
  output logic [15:0] regWdata,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdata
);
  initial begin
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // callers pass only the bits they acknowledge, so late sets survive
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd
endmodule : asf_host_model

// ==== testbench/asf_alarm_tb.sv ====
// self-checking bench for the alarm aggregation block
// assumes: asf_defs.svh on the include path; host model drives the register port
`timescale 1ns/1ps
`include "asf_defs.svh"
module asf_alarm_tb;
  import asf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr;
  logic [15:0] regWdata, regRdata, secSafe = '0, pfFlags = '0;
  logic regWr, regRd;
  logic [7:0] hwSafe = '0;
  logic [23:0] saFlags = '0, saMask = '0;
  logic [31:0] pfaFlags = '0, pfaMask = '0;
  logic initB = 1'b0, initD = 1'b0, fullP = 1'b0, scanP = 1'b0, chgOff = 1'b0, dsgOff = 1'b0;
  logic stackLow = 1'b0, fuseOwn = 1'b0, fuseSense = 1'b0, balance = 1'b0, woken = 1'b0;
  logic chgFault = 1'b0, dsgFault = 1'b0;
  asf_power_t powerMode = ASF_PM_NORMAL;
  logic [1:0] alertFxn = 2'h2;
  logic alertPin, chgOut, chgOe, dsgOut, dsgOe;
  int nMismatch = 0, nChecks = 0, cycles = 0;

  always #2 clk = ~clk;

  asf_host_model u_host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));

  asf_alarm u_dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .secondarySafetyFlags(secSafe),
    .hwSafetyFlags(hwSafe), .permFailFlags(pfFlags), .safetyAlertFlags(saFlags),
    .safetyAlertMask(saMask), .permFailAlertFlags(pfaFlags), .permFailAlertMask(pfaMask),
    .initBegun(initB), .initDone(initD), .fullLoopPulse(fullP), .singleScanPulse(scanP),
    .chargeFetOff(chgOff), .dischargeFetOff(dsgOff), .stackBelowShutdown(stackLow),
    .fuseDriveOwn(fuseOwn), .fuseSense(fuseSense), .balancingActive(balance),
    .wokenFromSleep(woken), .chargeDisableFault(chgFault),
    .dischargeDisableFault(dsgFault), .powerMode(powerMode), .alertPinFunction(alertFxn),
    .alertPinState(alertPin), .chargeFaultPinOut(chgOut), .chargeFaultPinOe(chgOe),
    .dischargeFaultPinOut(dsgOut), .dischargeFaultPinOe(dsgOe));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // waits n edges; outputs are looked at 1 ns later, once the flops have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic pulse(input bit full);
    @(posedge clk);
    if (full) begin
      fullP <= 1'b1;
    end else begin
      scanP <= 1'b1;
    end
    @(posedge clk);
    fullP <= 1'b0;
    scanP <= 1'b0;
  endtask : pulse

  task automatic t_reset();
    rdchk(`ASF_OFS_MASK, 16'h0000);
    rdchk(`ASF_OFS_LATCHED, 16'h0000);
    rdchk(`ASF_OFS_CONFIG, 16'h0000);
    rdchk(8'h70, 16'h0000);
    u_host.wr(`ASF_OFS_RAW, 16'hFFFF);
    rdchk(`ASF_OFS_RAW, 16'h0000);
    $display("reset test done");
  endtask : t_reset

  task automatic t_raw();
    @(posedge clk);
    secSafe <= 16'h0100;
    pfFlags <= 16'h8000;
    saFlags <= 24'h000100;
    saMask <= 24'h000100;
    pfaFlags <= 32'h00000001;
    pfaMask <= 32'h00000002;
    initB <= 1'b1;
    chgOff <= 1'b1;
    stackLow <= 1'b1;
    fuseSense <= 1'b1;
    balance <= 1'b1;
    step(4);
    rdchk(`ASF_OFS_RAW, 16'hB45C);
    @(posedge clk);
    secSafe <= 16'h0000;
    pfFlags <= 16'h0000;
    hwSafe <= 8'h80;
    saMask <= 24'h000200;
    pfaFlags <= 32'h00000002;
    initB <= 1'b0;
    initD <= 1'b1;
    chgOff <= 1'b0;
    dsgOff <= 1'b1;
    stackLow <= 1'b0;
    fuseSense <= 1'b0;
    fuseOwn <= 1'b1;
    balance <= 1'b0;
    woken <= 1'b1;
    pulse(1'b0);
    pulse(1'b1);
    step(4);
    rdchk(`ASF_OFS_RAW, 16'h4AAB);
    @(posedge clk);
    hwSafe <= 8'h00;
    pfaFlags <= 32'h00000000;
    initD <= 1'b0;
    dsgOff <= 1'b0;
    fuseOwn <= 1'b0;
    woken <= 1'b0;
    step(4);
    rdchk(`ASF_OFS_RAW, 16'h0082);
    $display("raw test done");
  endtask : t_raw

  task automatic t_latch();
    u_host.wr(`ASF_OFS_LATCHED, 16'hFFFF);
    u_host.wr(`ASF_OFS_MASK, 16'h0001);
    rdchk(`ASF_OFS_MASK, 16'h0001);
    @(posedge clk);
    woken <= 1'b1;
    balance <= 1'b1;
    step(3);
    chk({15'h0, alertPin}, 16'h0001);
    rdchk(`ASF_OFS_PINSTATE, 16'h0001);
    rdchk(`ASF_OFS_LATCHED, 16'h0001);
    @(posedge clk);
    woken <= 1'b0;
    u_host.wr(`ASF_OFS_LATCHED, 16'h0000);
    rdchk(`ASF_OFS_LATCHED, 16'h0001);
    @(posedge clk);
    alertFxn <= 2'h1;
    step(2);
    chk({15'h0, alertPin}, 16'h0000);
    @(posedge clk);
    alertFxn <= 2'h2;
    u_host.wr(`ASF_OFS_LATCHED, 16'h0001);
    step(2);
    chk({15'h0, alertPin}, 16'h0000);
    u_host.wr(`ASF_OFS_MASK, 16'h0086);
    @(posedge clk);
    balance <= 1'b0;
    @(posedge clk);
    balance <= 1'b1;
    rdchk(`ASF_OFS_LATCHED, 16'h0004);
    u_host.wr(`ASF_OFS_LATCHED, 16'h0004);
    pulse(1'b0);
    rdchk(`ASF_OFS_LATCHED, 16'h0002);
    u_host.wr(`ASF_OFS_LATCHED, 16'h0002);
    pulse(1'b0);
    pulse(1'b1);
    rdchk(`ASF_OFS_LATCHED, 16'h0082);
    $display("latch test done");
  endtask : t_latch

  task automatic t_fault();
    u_host.wr(`ASF_OFS_CONFIG, 16'h0034);
    // faults raised one at a time so a swapped pin hookup shows up
    @(posedge clk);
    chgFault <= 1'b1;
    step(2);
    chk({12'h000, chgOut, chgOe, dsgOut, dsgOe}, 16'h000F);
    @(posedge clk);
    chgFault <= 1'b0;
    dsgFault <= 1'b1;
    step(2);
    chk({12'h000, chgOut, chgOe, dsgOut, dsgOe}, 16'h0005);
    @(posedge clk);
    dsgFault <= 1'b0;
    step(2);
    chk({12'h000, chgOut, chgOe, dsgOut, dsgOe}, 16'h0007);
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      powerMode <= asf_power_t'(m);
      step(2);
      chk({14'h0000, chgOe, dsgOe}, (m == 3) ? 16'h0000 : 16'h0003);
    end
    $display("fault pin test done");
  endtask : t_fault

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      nMismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_raw();
    t_latch();
    t_fault();
    tally_and_finish();
  end
endmodule : asf_alarm_tb
